// ### hdl/parameter_target_pipeline.sv
/*
  Parameter target pipeline: eight software-loaded stages split into up to four
  shifting segments, each feeding one destination parameter on internal start.
  Assumes a one-cycle internal start pulse on clk and a plain register port.
*/
// Contract
// - Eight stage registers at consecutive addresses, split into at most four segments.
// - Destinations: target position, compare position, gear factor, global settings.
// - Four select bits each enable one destination's pipeline, bit order fixed.
// - Active pipelines equal set select bits; zero select disables pipelining.
// - Depths: eight for one, four each for two, 3-3-2, two each for four.
// - Two destinations: lower bit from stage 0, higher from stage 4.
// - Three destinations ascending from stages 0, 3, 6; last segment two stages.
// - On start each enabled destination takes its segment's first stage.
// - Write-back mask copies destination value into selected stages on start.
// - Write-back only into stages of that destination's own segment.
// - Write-back source chosen automatically from the active mapping.
// - On start each unmasked stage except its segment's last takes its next-higher stage, alongside the load; the last holds or takes a same-cycle write.
`timescale 1ns/1ps
module parameter_target_pipeline (
  input wire logic clk,
  input wire logic nrst,
  input wire logic startPulse,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  output logic [31:0] targetPosition,
  output logic [31:0] comparePosition,
  output logic [31:0] gearFactor,
  output logic [31:0] globalSettings,
  output logic [3:0] pipeSelect
);

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic rstSync1;
  logic rstSync2;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  wire logic rstN = rstSync2;

  // ---------------------------------------------------------------------------
  // Storage and map
  // ---------------------------------------------------------------------------
  logic [31:0] stage [8];
  logic [31:0] dest [4];
  logic [7:0] writebackMask;
  logic [15:0] stageOwner;
  logic [7:0] stageLast;
  logic [11:0] destSource;
  logic pipeOn;

  ptp_segment_map u_map (
    .pipeSelect(pipeSelect),
    .stageOwner(stageOwner),
    .stageLast(stageLast),
    .destSource(destSource)
  );

  assign pipeOn = (pipeSelect != 4'h0);
  assign targetPosition = dest[ptp_pkg::DEST_TARGET];
  assign comparePosition = dest[ptp_pkg::DEST_COMPARE];
  assign gearFactor = dest[ptp_pkg::DEST_GEAR];
  assign globalSettings = dest[ptp_pkg::DEST_GLOBAL];

  function automatic logic isStage(input logic [7:0] a);
    isStage = (a >= ptp_pkg::ADDR_PIPELINE_STAGE0) && (a <= ptp_pkg::ADDR_PIPELINE_STAGE7);
  endfunction

  function automatic logic [7:0] destAddr(input int d);
    logic [7:0] a;
    a = ptp_pkg::ADDR_TARGET_POSITION;
    unique case (d)
      1: a = ptp_pkg::ADDR_COMPARE_POSITION;
      2: a = ptp_pkg::ADDR_GEAR_FACTOR;
      3: a = ptp_pkg::ADDR_GLOBAL_SETTINGS;
      default: a = ptp_pkg::ADDR_TARGET_POSITION;
    endcase
    destAddr = a;
  endfunction

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pipeSelect <= ptp_pkg::RESET_PIPE_SELECT;
    end else if (regWrite && regAddr == ptp_pkg::ADDR_START_CONFIGURATION) begin
      pipeSelect <= regWrData[ptp_pkg::PIPE_SELECT_MSB:ptp_pkg::PIPE_SELECT_LSB];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      writebackMask <= ptp_pkg::RESET_WRITEBACK_MASK;
    end else if (regWrite && regAddr == ptp_pkg::ADDR_WRITEBACK_MASK_REG) begin
      writebackMask <= regWrData[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Destinations
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int d = 0; d < ptp_pkg::NUM_DEST; d++) begin
        dest[d] <= ptp_pkg::RESET_WORD;
      end
    end else begin
      for (int d = 0; d < ptp_pkg::NUM_DEST; d++) begin
        if (startPulse && pipeSelect[d]) begin
          dest[d] <= stage[destSource[d*3 +: 3]];
        end else if (regWrite && regAddr == destAddr(d)) begin
          dest[d] <= regWrData;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int s = 0; s < ptp_pkg::NUM_STAGES; s++) begin
        stage[s] <= ptp_pkg::RESET_WORD;
      end
    end else begin
      for (int s = 0; s < ptp_pkg::NUM_STAGES; s++) begin
        if (startPulse && pipeOn && writebackMask[s]) begin
          // Owner's current value, own segment only
          stage[s] <= dest[stageOwner[s*2 +: 2]];
        end else if (startPulse && pipeOn && !stageLast[s]) begin
          stage[s] <= stage[(s + 1) % ptp_pkg::NUM_STAGES];
        end else if (regWrite && regAddr == ptp_pkg::ADDR_PIPELINE_STAGE0 + 8'(s)) begin
          stage[s] <= regWrData;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRdData <= ptp_pkg::RESET_WORD;
    end else if (regRead) begin
      if (isStage(regAddr)) begin
        regRdData <= stage[regAddr[2:0]];
      end else if (regAddr == ptp_pkg::ADDR_START_CONFIGURATION) begin
        regRdData <= {28'h0, pipeSelect};
      end else if (regAddr == ptp_pkg::ADDR_WRITEBACK_MASK_REG) begin
        regRdData <= {24'h0, writebackMask};
      end else if (regAddr == ptp_pkg::ADDR_TARGET_POSITION) begin
        regRdData <= dest[0];
      end else if (regAddr == ptp_pkg::ADDR_COMPARE_POSITION) begin
        regRdData <= dest[1];
      end else if (regAddr == ptp_pkg::ADDR_GEAR_FACTOR) begin
        regRdData <= dest[2];
      end else if (regAddr == ptp_pkg::ADDR_GLOBAL_SETTINGS) begin
        regRdData <= dest[3];
      end else begin
        regRdData <= ptp_pkg::RESET_WORD;
      end
    end else begin
      regRdData <= ptp_pkg::RESET_WORD;
    end
  end

endmodule

// ### hdl/ptp_pkg.sv
/*
  Package for the parameter target pipeline: register indices, field layouts,
  reset values and the segment map helpers.
  Assumes a 32-bit register port with word-indexed addresses.
*/
package ptp_pkg;

  // ---------------------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_GLOBAL_SETTINGS = 8'h00;
  localparam logic [7:0] ADDR_START_CONFIGURATION = 8'h02;
  localparam logic [7:0] ADDR_GEAR_FACTOR = 8'h12;
  localparam logic [7:0] ADDR_COMPARE_POSITION = 8'h32;
  localparam logic [7:0] ADDR_TARGET_POSITION = 8'h37;
  localparam logic [7:0] ADDR_PIPELINE_STAGE0 = 8'h38;
  localparam logic [7:0] ADDR_PIPELINE_STAGE7 = 8'h3f;
  localparam logic [7:0] ADDR_WRITEBACK_STAGE_MASK = 8'h3c;
  localparam logic [7:0] ADDR_WRITEBACK_MASK_REG = 8'h50;

  // ---------------------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------------------
  localparam int PIPE_SELECT_LSB = 0;
  localparam int PIPE_SELECT_MSB = 3;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [3:0] RESET_PIPE_SELECT = 4'h0;
  localparam logic [7:0] RESET_WRITEBACK_MASK = 8'h00;

  localparam int NUM_STAGES = 8;
  localparam int NUM_DEST = 4;

  // Destination index 0..3
  localparam logic [1:0] DEST_TARGET = 2'h0;
  localparam logic [1:0] DEST_COMPARE = 2'h1;
  localparam logic [1:0] DEST_GEAR = 2'h2;
  localparam logic [1:0] DEST_GLOBAL = 2'h3;

  // ---------------------------------------------------------------------------
  // Map helpers
  // ---------------------------------------------------------------------------
  function automatic logic [2:0] ptp_count(input logic [3:0] sel);
    ptp_count = {2'h0, sel[0]} + {2'h0, sel[1]} + {2'h0, sel[2]} + {2'h0, sel[3]};
  endfunction

  // First stage of the segment with ordinal k among enabled destinations
  function automatic logic [2:0] ptp_seg_start(input logic [2:0] cnt, input logic [1:0] k);
    logic [2:0] s;
    s = 3'h0;
    unique case (cnt)
      3'h2: s = (k == 2'h0) ? 3'h0 : 3'h4;
      3'h3: s = (k == 2'h0) ? 3'h0 : ((k == 2'h1) ? 3'h3 : 3'h6);
      3'h4: s = {k, 1'b0};
      default: s = 3'h0;
    endcase
    ptp_seg_start = s;
  endfunction

endpackage

// ### hdl/ptp_segment_map.sv
/*
  Segment map: from the pipeline select field, derives for every stage the
  destination whose segment owns it and whether it is its segment's last stage,
  and for every destination the stage that feeds it.
  Assumes a select value from a register on the same clock.
*/
`timescale 1ns/1ps
module ptp_segment_map (
  input wire logic [3:0] pipeSelect,
  output logic [15:0] stageOwner,
  output logic [7:0] stageLast,
  output logic [11:0] destSource
);

  // ---------------------------------------------------------------------------
  // Mapping
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [2:0] cnt;
    logic [1:0] ord;
    logic [2:0] st;
    logic [2:0] starts [4];
    logic [1:0] dests [4];
    cnt = 3'h0;
    ord = 2'h0;
    st = 3'h0;
    stageOwner = 16'h0000;
    stageLast = 8'h00;
    destSource = 12'h000;
    for (int i = 0; i < 4; i++) begin
      starts[i] = 3'h0;
      dests[i] = 2'h0;
    end
    cnt = ptp_pkg::ptp_count(pipeSelect);
    // Ascending select-bit order of segments
    for (int d = 0; d < ptp_pkg::NUM_DEST; d++) begin
      if (pipeSelect[d]) begin
        st = ptp_pkg::ptp_seg_start(cnt, ord);
        starts[ord] = st;
        dests[ord] = d[1:0];
        destSource[d*3 +: 3] = st;
        ord = ord + 2'h1;
      end
    end
    // Ownership and segment ends
    for (int s = 0; s < ptp_pkg::NUM_STAGES; s++) begin
      for (int k = 0; k < 4; k++) begin
        if ((k < int'(cnt)) && (s >= int'(starts[k]))) begin
          stageOwner[s*2 +: 2] = dests[k];
        end
      end
      if (s == ptp_pkg::NUM_STAGES - 1) begin
        stageLast[s] = 1'b1;
      end else begin
        for (int k = 1; k < 4; k++) begin
          if ((k < int'(cnt)) && (s + 1 == int'(starts[k]))) begin
            stageLast[s] = 1'b1;
          end
        end
      end
    end
  end

endmodule

// ### test/ptp_checker_sva.sv
/*
  Port checker for the parameter target pipeline.
  Assumes it is bound to the top module; sees its ports only.
*/
`timescale 1ns/1ps
module ptp_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic startPulse,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic [31:0] targetPosition,
  input wire logic [31:0] comparePosition,
  input wire logic [31:0] gearFactor,
  input wire logic [31:0] globalSettings,
  input wire logic [3:0] pipeSelect
);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (!regRead |=> regRdData == 32'h0)
    else $error("read data not idle");
  a_select_write: assert property (regWrite && regAddr == 8'h02
    |=> pipeSelect == $past(regWrData[3:0])) else $error("select not written");
  a_select_hold: assert property (!(regWrite && regAddr == 8'h02)
    |=> $stable(pipeSelect)) else $error("select changed");
  a_select_read: assert property (regRead && regAddr == 8'h02
    |=> regRdData == {28'h0, $past(pipeSelect)}) else $error("select read wrong");
  a_target_hold: assert property (startPulse && !pipeSelect[0] && !regWrite
    |=> $stable(targetPosition)) else $error("target moved");
  a_compare_hold: assert property (startPulse && !pipeSelect[1] && !regWrite
    |=> $stable(comparePosition)) else $error("compare moved");
  a_gear_hold: assert property (startPulse && !pipeSelect[2] && !regWrite
    |=> $stable(gearFactor)) else $error("gear moved");
  a_global_hold: assert property (startPulse && !pipeSelect[3] && !regWrite
    |=> $stable(globalSettings)) else $error("global moved");
  a_target_write: assert property (regWrite && regAddr == 8'h37 && !startPulse
    |=> targetPosition == $past(regWrData)) else $error("target not written");
endmodule

// ### test/parameter_target_pipeline_test.sv
/*
  Self-checking test of the parameter target pipeline against a model.
  Assumes ptp_pkg, the design and ptp_checker are compiled first.
*/
`timescale 1ns/1ps
module parameter_target_pipeline_test;
  logic clk = 1'b0, nrst = 1'b0, startPulse = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, regRdData, targetPosition, comparePosition;
  logic [31:0] gearFactor, globalSettings, seed = 32'h4e90;
  logic [3:0] pipeSelect, sel = 4'h0;
  logic [7:0] wb = 8'h00;
  logic [31:0] stg [8] = '{default: 32'h0};
  logic [31:0] dst [4] = '{default: 32'h0};
  logic [7:0] dAddr [4] = '{8'h37, 8'h32, 8'h12, 8'h00};
  int n_errors = 0, compares = 0;
  parameter_target_pipeline dut (.clk, .nrst, .startPulse, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .targetPosition, .comparePosition, .gearFactor,
    .globalSettings, .pipeSelect);
  initial begin
    forever #2 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // Model and helpers
  // ---------------------------------------------------------------
  function logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int segStart(logic [3:0] s, int d);
    int k = 0, c = 0;
    for (int i = 0; i < 4; i++) begin
      c += s[i];
      if (i < d) k += s[i];
    end
    return c == 2 ? k * 4 : c == 3 ? k * 3 : c == 4 ? k * 2 : 0;
  endfunction
  task automatic startModel();
    logic [31:0] ns [8];
    int o;
    logic lst;
    if (sel == 4'h0) return;
    for (int n = 0; n < 8; n++) begin
      o = 0;
      lst = (n == 7);
      for (int d = 0; d < 4; d++) begin
        if (sel[d] && segStart(sel, d) <= n) o = d;
        if (sel[d] && segStart(sel, d) == n + 1) lst = 1'b1;
      end
      ns[n] = wb[n] ? dst[o] : lst ? stg[n] : stg[(n + 1) % 8];
    end
    for (int d = 0; d < 4; d++) begin
      if (sel[d]) dst[d] = stg[segStart(sel, d)];
    end
    stg = ns;
  endtask
  task check(string nm, logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task rdChk(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 check($sformatf("reg %h", a), regRdData, e);
  endtask
  task pulse(int n);
    @(posedge clk);
    startPulse <= 1'b1;
    repeat (n) begin
      @(posedge clk);
      startModel();
    end
    startPulse <= 1'b0;
  endtask
  task checkAll();
    rdChk(8'h02, {28'h0, sel});
    rdChk(8'h50, {24'h0, wb});
    for (int n = 0; n < 8; n++) rdChk(8'h38 + 8'(n), stg[n]);
    for (int d = 0; d < 4; d++) rdChk(dAddr[d], dst[d]);
    check("targetPosition", targetPosition, dst[0]);
    check("comparePosition", comparePosition, dst[1]);
    check("gearFactor", gearFactor, dst[2]);
    check("globalSettings", globalSettings, dst[3]);
    check("pipeSelect", {28'h0, pipeSelect}, {28'h0, sel});
  endtask
  task print_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    checkAll();
    wr(8'h7f, 32'h5a5a_5a5a);
    rdChk(8'h7f, 32'h0);
    for (int i = 0; i < 24; i++) begin
      sel = i < 16 ? 4'(i) : 4'(nxt());
      wb = i == 1 ? 8'h10 : i == 0 ? 8'hff : i % 3 == 0 ? 8'h00 : 8'(nxt());
      wr(8'h02, {28'h0, sel});
      wr(8'h50, {24'h0, wb});
      for (int n = 0; n < 8; n++) begin
        stg[n] = nxt();
        wr(8'h38 + 8'(n), stg[n]);
      end
      for (int d = 0; d < 4; d++) begin
        dst[d] = nxt();
        wr(dAddr[d], dst[d]);
      end
      pulse(1);
      checkAll();
      pulse(2 + i % 3);
      checkAll();
    end
    print_verdict();
  end
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
endmodule
bind parameter_target_pipeline ptp_checker u_chk (.clk, .nrst, .startPulse, .regAddr,
  .regWrData, .regWrite, .regRead, .regRdData, .targetPosition, .comparePosition,
  .gearFactor, .globalSettings, .pipeSelect);
